// >>> rtl/amla_top.sv
// Converter control: mode, sample rate, limit alert and register port
`timescale 1ns/100ps
module amla_top
	import amla_pkg::*;
#(
	parameter int unsigned FAST_PERIOD_CYC = AMLA_FAST_PERIOD_CYC,
	parameter logic [6:0] DEV_ADDR = 7'h15 // Arbitrary default
)
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [2:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// Result link from the converter core
	input wire logic lk_clk_in,
	input wire logic lk_frame_in,
	input wire logic lk_data_in,
	output logic conv_start_out,
	output logic pwr_down_out,
	// Alert response arbitration
	input wire logic ara_start_in,
	input wire logic ara_next_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Alert pin and interrupt
	output logic alert_out,
	output logic alert_oe_out,
	output logic irq_out
);
	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] lower;
		logic [15:0] upper;
		logic [15:0] result;
		logic [15:0] rdata;
		logic [2:0] sts;
		logic [2:0] en;
		logic irq;
		logic lk_c1;
		logic lk_c2;
		logic lk_c3;
		logic lk_f1;
		logic lk_f2;
		logic lk_f3;
		logic lk_d1;
		logic lk_d2;
		logic [15:0] shift;
		logic [4:0] nbits;
		logic busy;
		logic start;
		logic [24:0] period_cnt;
		logic [9:0] rdy_cnt;
		logic alert;
		logic alert_oe;
		amla_ara_st_t ara;
		logic [2:0] ara_idx;
		logic ara_oe;
		logic step;
		logic clr;
		logic que_wr;
		logic pwr;
	} amla_top_st_t;

	amla_top_st_t q;
	amla_top_st_t n;
	amla_cmp_if cmp_bus ();
	logic single;
	logic rdy_mode;
	logic active;
	logic [2:0] ev;

	// ==========================================
	// Comparator
	amla_cmp u_cmp (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.cmp_bus(cmp_bus)
	);

	// Comparator inputs from core state
	assign cmp_bus.step = q.step;
	assign cmp_bus.result = q.result;
	assign cmp_bus.upper = q.upper;
	assign cmp_bus.lower = q.lower;
	assign cmp_bus.style = q.cfg[AMLA_STYLE_BIT];
	assign cmp_bus.hold = q.cfg[AMLA_HOLD_BIT];
	assign cmp_bus.que = q.cfg[AMLA_QUE_HI:AMLA_QUE_LO];
	assign cmp_bus.que_wr = q.que_wr;
	assign cmp_bus.clr = q.clr;

	// ==========================================
	// Next state
	always_comb
	begin
		n = q;
		ev = 3'h0;
		n.start = 1'b0;
		n.step = 1'b0;
		n.clr = 1'b0;
		n.que_wr = 1'b0;
		single = q.cfg[AMLA_MODE_BIT];
		rdy_mode = q.upper[15] && !q.lower[15];

		// Link inputs pass two flops before use
		n.lk_c1 = lk_clk_in;
		n.lk_c2 = q.lk_c1;
		n.lk_c3 = q.lk_c2;
		n.lk_f1 = lk_frame_in;
		n.lk_f2 = q.lk_f1;
		n.lk_f3 = q.lk_f2;
		n.lk_d1 = lk_data_in;
		n.lk_d2 = q.lk_d1;

		// Register writes
		if (wr_in)
		begin
			case (addr_in)
				AMLA_ADDR_CONFIG:
				begin
					n.cfg = wdata_in & AMLA_CFG_STORE;
					n.que_wr = 1'b1;
					if (wdata_in[AMLA_OS_BIT] && single && !q.busy)
						n.start = 1'b1;
				end
				AMLA_ADDR_LOWER: n.lower = wdata_in;
				AMLA_ADDR_UPPER: n.upper = wdata_in;
				AMLA_ADDR_CLEAR: n.sts = q.sts & ~wdata_in[2:0];
				AMLA_ADDR_ENABLE: n.en = wdata_in[2:0];
				default: ;
			endcase
		end

		// Register reads, data stand one cycle later
		n.rdata = 16'h0000;
		if (rd_in)
		begin
			case (addr_in)
				AMLA_ADDR_RESULT:
				begin
					n.rdata = q.result;
					n.clr = 1'b1;
				end
				AMLA_ADDR_CONFIG: n.rdata = {!q.busy, q.cfg[14:0]};
				AMLA_ADDR_LOWER: n.rdata = q.lower;
				AMLA_ADDR_UPPER: n.rdata = q.upper;
				AMLA_ADDR_STATUS: n.rdata = {13'h0000, q.sts};
				AMLA_ADDR_ENABLE: n.rdata = {13'h0000, q.en};
				default: n.rdata = 16'h0000;
			endcase
		end

		// Sample timer for continuous mode
		if (single)
			n.period_cnt = 25'h0000000;
		else if (q.period_cnt == 25'h0000000)
		begin
			n.period_cnt = 25'(FAST_PERIOD_CYC * amla_rate_mult(q.cfg[AMLA_RATE_HI:AMLA_RATE_LO]) - 1);
			if (!q.busy)
				n.start = 1'b1;
		end
		else
			n.period_cnt = q.period_cnt - 25'h0000001;
		if (n.start)
			n.busy = 1'b1;

		// Result word arrives MSB first on link clock rises
		if (q.lk_f2 && !q.lk_f3)
			n.nbits = 5'h00;
		else if (q.lk_f2 && q.lk_c2 && !q.lk_c3 && q.nbits != AMLA_RES_BITS)
		begin
			n.shift = {q.shift[14:0], q.lk_d2};
			n.nbits = q.nbits + 5'h01;
		end
		if (!q.lk_f2 && q.lk_f3 && q.busy && q.nbits == AMLA_RES_BITS)
		begin
			n.result = q.shift;
			n.busy = 1'b0;
			n.step = 1'b1;
			ev[AMLA_EV_DONE] = 1'b1;
			n.rdy_cnt = 10'(AMLA_RDY_PULSE_CYC);
		end
		else if (q.rdy_cnt != 10'h000)
			n.rdy_cnt = q.rdy_cnt - 10'h001;

		// Alert response: send address bits, back off on loss
		case (q.ara)
			AMLA_ARA_IDLE:
			begin
				n.ara_oe = 1'b0;
				if (ara_start_in && cmp_bus.act && !rdy_mode && q.alert_oe)
				begin
					n.ara = AMLA_ARA_SEND;
					n.ara_idx = 3'h6;
					n.ara_oe = !DEV_ADDR[6];
				end
			end
			AMLA_ARA_SEND:
			begin
				if (ara_next_in)
				begin
					if (!q.ara_oe && !sda_in)
					begin
						n.ara = AMLA_ARA_IDLE;
						n.ara_oe = 1'b0;
					end
					else if (q.ara_idx == 3'h0)
					begin
						n.ara = AMLA_ARA_IDLE;
						n.ara_oe = 1'b0;
						n.clr = 1'b1;
						ev[AMLA_EV_ARA] = 1'b1;
					end
					else
					begin
						n.ara_idx = q.ara_idx - 3'h1;
						n.ara_oe = !DEV_ADDR[n.ara_idx];
					end
				end
			end
			default: n.ara = AMLA_ARA_IDLE;
		endcase

		// Alert pin level and enable
		if (rdy_mode)
			active = single ? !q.busy : (q.rdy_cnt != 10'h000);
		else
			active = cmp_bus.act;
		n.alert = q.cfg[AMLA_POL_BIT] ? active : !active;
		n.alert_oe = q.cfg[AMLA_QUE_HI:AMLA_QUE_LO] != AMLA_QUE_OFF;
		n.pwr = n.cfg[AMLA_MODE_BIT] && !n.busy;

		// Sticky events, a set beats a same-cycle clear
		ev[AMLA_EV_ALERT] = cmp_bus.rise;
		n.sts = n.sts | ev;
		n.irq = |(n.sts & n.en);
	end

	// ==========================================
	// State register
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			q <= '0;
			q.cfg <= AMLA_CONFIG_RST & AMLA_CFG_STORE;
			q.lower <= AMLA_LOWER_RST;
			q.upper <= AMLA_UPPER_RST;
			q.result <= AMLA_RESULT_RST;
			q.alert <= 1'b1;
			q.pwr <= 1'b1;
			q.ara <= AMLA_ARA_IDLE;
		end
		else
			q <= n;
	end

	// Outputs straight from flops, except sda_out, which is tied low
	assign rdata_out = q.rdata;
	assign conv_start_out = q.start;
	assign pwr_down_out = q.pwr;
	assign sda_out = 1'b0;
	assign sda_oe_out = q.ara_oe;
	assign alert_out = q.alert;
	assign alert_oe_out = q.alert_oe;
	assign irq_out = q.irq;

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	property p_os_read;
		rd_in && addr_in == AMLA_ADDR_CONFIG |=> rdata_out[AMLA_OS_BIT] == !$past(q.busy);
	endproperty
	a_os_read: assert property (p_os_read) else $error("idle bit read wrong");

	property p_single_start;
		wr_in && addr_in == AMLA_ADDR_CONFIG && wdata_in[AMLA_OS_BIT] && q.cfg[AMLA_MODE_BIT] && !q.busy
			|=> conv_start_out ##1 !conv_start_out;
	endproperty
	a_single_start: assert property (p_single_start) else $error("single conversion not started");

	property p_no_start_single;
		q.cfg[AMLA_MODE_BIT] && !(wr_in && addr_in == AMLA_ADDR_CONFIG) |=> !conv_start_out;
	endproperty
	a_no_start_single: assert property (p_no_start_single) else $error("start without trigger");

	property p_result_load;
		!q.lk_f2 && q.lk_f3 && q.busy && q.nbits == AMLA_RES_BITS |=> q.result == $past(q.shift) && !q.busy;
	endproperty
	a_result_load: assert property (p_result_load) else $error("result not loaded");

	property p_que_off;
		q.cfg[AMLA_QUE_HI:AMLA_QUE_LO] == AMLA_QUE_OFF |=> !alert_oe_out;
	endproperty
	a_que_off: assert property (p_que_off) else $error("alert pin driven while disabled");

	property p_polarity;
		!rdy_mode && $stable(q.cfg) |=> alert_out == ($past(q.cfg[AMLA_POL_BIT]) ~^ $past(cmp_bus.act));
	endproperty
	a_polarity: assert property (p_polarity) else $error("alert level wrong");

	property p_ready_pulse;
		rdy_mode && !single && q.step && $stable(q.cfg) && $stable(q.upper) && $stable(q.lower)
			|=> alert_out == $past(q.cfg[AMLA_POL_BIT]);
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse missing");

	property p_ara_loss;
		q.ara == AMLA_ARA_SEND && ara_next_in && !q.ara_oe && !sda_in |=> !sda_oe_out ##1 !sda_oe_out;
	endproperty
	a_ara_loss: assert property (p_ara_loss) else $error("lost arbitration but still driving");

	property p_irq;
		##1 irq_out == |($past(n.sts) & $past(n.en));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule

// >>> rtl/amla_pkg.sv
// Shared constants and types for the converter mode and limit alert block
package amla_pkg;
	// ==========================================
	// Register offsets
	localparam logic [2:0] AMLA_ADDR_RESULT = 3'h0;
	localparam logic [2:0] AMLA_ADDR_CONFIG = 3'h1;
	localparam logic [2:0] AMLA_ADDR_LOWER = 3'h2;
	localparam logic [2:0] AMLA_ADDR_UPPER = 3'h3;
	localparam logic [2:0] AMLA_ADDR_STATUS = 3'h4;
	localparam logic [2:0] AMLA_ADDR_CLEAR = 3'h5;
	localparam logic [2:0] AMLA_ADDR_ENABLE = 3'h6;
	// ==========================================
	// Setup word field positions
	localparam int AMLA_OS_BIT = 15;
	localparam int AMLA_MODE_BIT = 8;
	localparam int AMLA_RATE_HI = 7;
	localparam int AMLA_RATE_LO = 5;
	localparam int AMLA_STYLE_BIT = 4;
	localparam int AMLA_POL_BIT = 3;
	localparam int AMLA_HOLD_BIT = 2;
	localparam int AMLA_QUE_HI = 1;
	localparam int AMLA_QUE_LO = 0;
	// ==========================================
	// Reset values and fixed codes
	localparam logic [15:0] AMLA_CONFIG_RST = 16'h8583;
	localparam logic [15:0] AMLA_LOWER_RST = 16'h8000;
	localparam logic [15:0] AMLA_UPPER_RST = 16'h7FFF;
	localparam logic [15:0] AMLA_RESULT_RST = 16'h0000;
	localparam logic [15:0] AMLA_CFG_STORE = 16'h7FFF;
	localparam logic [1:0] AMLA_QUE_OFF = 2'h3;
	localparam logic [4:0] AMLA_RES_BITS = 5'h10;
	// ==========================================
	// Event bits of status, clear and enable
	localparam int AMLA_EV_DONE = 0;
	localparam int AMLA_EV_ALERT = 1;
	localparam int AMLA_EV_ARA = 2;
	// ==========================================
	// Timing
	localparam int unsigned AMLA_CLK_PERIOD_NS = 8;
	localparam int unsigned AMLA_FAST_PERIOD_NS = 1000000;
	localparam int unsigned AMLA_FAST_PERIOD_CYC = AMLA_FAST_PERIOD_NS / AMLA_CLK_PERIOD_NS;
	localparam int unsigned AMLA_RDY_PULSE_NS = 8000;
	localparam int unsigned AMLA_RDY_PULSE_CYC = (AMLA_RDY_PULSE_NS + AMLA_CLK_PERIOD_NS - 1) / AMLA_CLK_PERIOD_NS;
	// ==========================================
	// Types
	typedef enum logic {AMLA_ARA_IDLE, AMLA_ARA_SEND} amla_ara_st_t;
	// Sample period in units of the 1000 per second period
	function automatic logic [7:0] amla_rate_mult(input logic [2:0] code);
		case (code)
			3'h0: amla_rate_mult = 8'hA0;
			3'h1: amla_rate_mult = 8'h50;
			3'h2: amla_rate_mult = 8'h28;
			3'h3: amla_rate_mult = 8'h14;
			3'h4: amla_rate_mult = 8'h0A;
			3'h5: amla_rate_mult = 8'h04;
			3'h6: amla_rate_mult = 8'h02;
			default: amla_rate_mult = 8'h01;
		endcase
	endfunction
	// Consecutive faults needed before the alert trips
	function automatic logic [2:0] amla_que_need(input logic [1:0] que);
		case (que)
			2'h0: amla_que_need = 3'h1;
			2'h1: amla_que_need = 3'h2;
			default: amla_que_need = 3'h4;
		endcase
	endfunction
endpackage

// >>> rtl/amla_cmp_if.sv
// Link between the control core and the limit comparator
`timescale 1ns/100ps
interface amla_cmp_if;
	logic step;
	logic [15:0] result;
	logic [15:0] upper;
	logic [15:0] lower;
	logic style;
	logic hold;
	logic [1:0] que;
	logic que_wr;
	logic clr;
	logic act;
	logic rise;
	modport core (output step, result, upper, lower, style, hold, que, que_wr, clr, input act, rise);
	modport cmp (input step, result, upper, lower, style, hold, que, que_wr, clr, output act, rise);
endinterface

// >>> rtl/amla_cmp.sv
// Limit comparator with fault count and alert hold
`timescale 1ns/100ps
module amla_cmp
	import amla_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Core link
	amla_cmp_if.cmp cmp_bus
);
	typedef struct packed {
		logic [2:0] cnt;
		logic act;
		logic rise;
	} amla_cmp_st_t;

	amla_cmp_st_t q;
	amla_cmp_st_t n;
	logic above;
	logic below;
	logic fault;
	logic [2:0] inc;

	// ==========================================
	// Compare and count
	always_comb
	begin
		n = q;
		n.rise = 1'b0;
		above = $signed(cmp_bus.result) > $signed(cmp_bus.upper);
		below = $signed(cmp_bus.result) < $signed(cmp_bus.lower);
		fault = cmp_bus.style ? (above | below) : above;
		inc = (q.cnt < 3'h4) ? q.cnt + 3'h1 : q.cnt;
		// Held alert ends on result read or won alert response
		if (cmp_bus.hold && cmp_bus.clr)
			n.act = 1'b0;
		if (cmp_bus.que == AMLA_QUE_OFF)
		begin
			n.cnt = 3'h0;
			n.act = 1'b0;
		end
		else if (cmp_bus.que_wr)
			n.cnt = 3'h0;
		else if (cmp_bus.step)
		begin
			if (fault)
			begin
				n.cnt = inc;
				if (inc >= amla_que_need(cmp_bus.que) && !q.act)
				begin
					n.act = 1'b1;
					n.rise = 1'b1;
				end
			end
			else
			begin
				n.cnt = 3'h0;
				if (!cmp_bus.hold && (cmp_bus.style || below))
					n.act = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			q <= '0;
		else
			q <= n;
	end

	assign cmp_bus.act = q.act;
	assign cmp_bus.rise = q.rise;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	property p_trip_count;
		cmp_bus.step && fault && !q.act && !cmp_bus.que_wr && inc >= amla_que_need(cmp_bus.que)
			&& cmp_bus.que != AMLA_QUE_OFF |=> q.act && q.rise;
	endproperty
	a_trip_count: assert property (p_trip_count) else $error("alert did not trip on count");

	property p_count_clear;
		(cmp_bus.step && !fault) || cmp_bus.que_wr |=> q.cnt == 3'h0;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("fault count not cleared");

	property p_hold_keeps;
		q.act && cmp_bus.hold && !cmp_bus.clr && cmp_bus.que != AMLA_QUE_OFF && $stable(cmp_bus.hold) |=> q.act;
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("held alert dropped");
endmodule

// >>> sim/amla_core_model.sv
// Behavioural converter core answering each start with one result frame
`timescale 1ns/100ps
module amla_core_model (
	// Clock and start request
	input wire logic ref_clk_in,
	input wire logic start_in,
	// Result to send
	input wire logic [15:0] value_in,
	// Serial link
	output logic lk_clk_out,
	output logic lk_frame_out,
	output logic lk_data_out
);
	// ==========================================
	// Frame sender
	// One frame per start; link clock still outside frames
	initial
	begin
		lk_clk_out = 1'h0;
		lk_frame_out = 1'h0;
		lk_data_out = 1'h0;
		forever
		begin
			@(posedge ref_clk_in);
			if (start_in)
			begin
				// Off-grid phase keeps link edges clear of clock rises
				#1.2 lk_frame_out = 1'h1;
				#100;
				for (int i = 15; i >= 0; i--)
				begin
					lk_data_out = value_in[i]; // MSB first
					#62.5 lk_clk_out = 1'h1;
					#62.5 lk_clk_out = 1'h0;
				end
				#62.5 lk_frame_out = 1'h0;
				lk_data_out = ~lk_data_out; // No stale bit after release
			end
		end
	end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the mode and limit alert block
`timescale 1ns/100ps
module tb;
	import amla_pkg::*;
	localparam logic [6:0] ADR = 7'h15; // Arbitrary address
	// ==========================================
	// Signals
	logic clk, rst, wr, rd, ara_s, ara_n, lk_c, lk_f, lk_d, sda_l, sda_x;
	logic cs, pd, sda_o, sda_oe, al, al_oe, irq;
	logic [2:0] addr;
	logic [15:0] wd, rdata, val;
	int num_errors = 0;
	int n_tests = 0;
	int nf = 0;
	int gap = 0;
	int last_gap = 0;
	assign sda_l = ~sda_oe & ~sda_x; // Pulled up unless either side pulls low
	always @(negedge lk_f) nf++;
	// Cycles between the last two conversion starts
	always @(posedge clk)
	begin
		if (cs)
		begin
			last_gap <= gap;
			gap <= 1;
		end
		else
			gap <= gap + 1;
	end
	amla_top #(.FAST_PERIOD_CYC(20), .DEV_ADDR(ADR)) uut (.ref_clk_in(clk), .rst_in(rst),
		.addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.lk_clk_in(lk_c), .lk_frame_in(lk_f), .lk_data_in(lk_d), .conv_start_out(cs),
		.pwr_down_out(pd), .ara_start_in(ara_s), .ara_next_in(ara_n), .sda_in(sda_l),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .alert_out(al), .alert_oe_out(al_oe), .irq_out(irq));
	amla_core_model core (.ref_clk_in(clk), .start_in(cs), .value_in(val),
		.lk_clk_out(lk_c), .lk_frame_out(lk_f), .lk_data_out(lk_d));
	// ==========================================
	// Bus, wait and compare tasks
	task automatic wrr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic chkw(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chkb(input logic g, input logic e);
		#1;
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 chkw(rdata, e);
	endtask
	task automatic wf(input int k);
		for (int i = 0; i < 4000 && nf <= k; i++)
			@(posedge clk);
		repeat (10) @(posedge clk);
		chkb(nf > k, 1'h1);
	endtask
	task automatic sg(input logic [15:0] v, input logic [15:0] c);
		int k;
		k = nf;
		val = v;
		wrr(3'h1, c);
		wf(k);
	endtask
	task automatic pulse(input logic s);
		@(posedge clk);
		if (s)
			ara_s <= 1'h1;
		else
			ara_n <= 1'h1;
		@(posedge clk);
		ara_s <= 1'h0;
		ara_n <= 1'h0;
		@(posedge clk);
		#1;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		rc(3'h1, 16'h8583);
		rc(3'h2, 16'h8000);
		rc(3'h3, 16'h7FFF);
		chkb(al_oe, 1'h0);
		chkb(pd, 1'h1);
		wrr(3'h0, 16'hFFFF);
		wrr(3'h7, 16'hFFFF);
		rc(3'h0, 16'h0000);
		rc(3'h7, 16'h0000);
		$display("test reset end");
	endtask
	task automatic t_single;
		int k;
		wrr(3'h2, 16'h0000);
		wrr(3'h3, 16'h0100);
		rc(3'h3, 16'h0100);
		k = nf;
		val = 16'h1234;
		wrr(3'h1, 16'h8580);
		#1 chkb(cs, 1'h1);
		chkb(pd, 1'h0);
		rc(3'h1, 16'h0580);
		wf(k);
		rc(3'h0, 16'h1234);
		chkb(al, 1'h0);
		chkb(al_oe, 1'h1);
		rc(3'h1, 16'h8580);
		sg(16'h0050, 16'h8580);
		chkb(al, 1'h0);
		sg(16'hFF00, 16'h8580);
		chkb(al, 1'h1);
		$display("test single end");
	endtask
	task automatic t_hold;
		sg(16'h1234, 16'h819C);
		chkb(al, 1'h1);
		sg(16'h0050, 16'h819C);
		chkb(al, 1'h1);
		rc(3'h0, 16'h0050);
		repeat (4) @(posedge clk);
		chkb(al, 1'h0);
		sg(16'hFF00, 16'h819C);
		chkb(al, 1'h1);
		pulse(1'h1);
		for (int i = 6; i >= 0; i--)
		begin
			chkb(sda_oe, ~ADR[i]);
			pulse(1'h0);
		end
		chkb(sda_oe, 1'h0);
		repeat (3) @(posedge clk);
		chkb(al, 1'h0);
		rc(3'h4, 16'h0007);
		// A lower address pulls low on our released bit
		sg(16'hFF00, 16'h819C);
		pulse(1'h1);
		pulse(1'h0);
		pulse(1'h0);
		chkb(sda_oe, ~ADR[4]);
		sda_x <= 1'h1;
		pulse(1'h0);
		sda_x <= 1'h0;
		chkb(sda_oe, 1'h0);
		pulse(1'h0);
		chkb(sda_oe, 1'h0);
		chkb(al, 1'h1);
		chkb(sda_o, 1'h0);
		$display("test hold end");
	endtask
	task automatic t_ready;
		int k;
		wrr(3'h3, 16'h8000);
		wrr(3'h2, 16'h0000);
		wrr(3'h1, 16'h0180);
		repeat (4) @(posedge clk);
		chkb(al, 1'h0);
		k = nf;
		val = 16'h0000;
		wrr(3'h1, 16'h8180);
		repeat (20) @(posedge clk);
		chkb(al, 1'h1);
		wf(k);
		chkb(al, 1'h0);
		// Continuous ready pulses at the slowest rate
		k = nf;
		wrr(3'h1, 16'h0000);
		wf(k);
		chkb(al, 1'h0);
		repeat (1010) @(posedge clk);
		chkb(al, 1'h1);
		k = nf;
		wf(k);
		wrr(3'h1, 16'h0180);
		chkw(last_gap[15:0], 16'h0C80);
		$display("test ready end");
	endtask
	task automatic t_irq;
		wrr(3'h5, 16'h0007);
		wrr(3'h6, 16'h0001);
		rc(3'h4, 16'h0000);
		chkb(irq, 1'h0);
		sg(16'h0000, 16'h8180);
		rc(3'h4, 16'h0001);
		chkb(irq, 1'h1);
		wrr(3'h6, 16'h0002);
		repeat (2) @(posedge clk);
		chkb(irq, 1'h0);
		wrr(3'h5, 16'h0001);
		rc(3'h4, 16'h0000);
		rc(3'h6, 16'h0002);
		rc(3'h5, 16'h0000);
		wrr(3'h1, 16'h0583);
		repeat (3) @(posedge clk);
		chkb(al_oe, 1'h0);
		$display("test irq end");
	endtask
	task automatic t_queue;
		int k;
		wrr(3'h3, 16'h0100);
		wrr(3'h2, 16'h0000);
		k = nf;
		val = 16'h1234;
		wrr(3'h1, 16'h00E1);
		repeat (3) @(posedge clk);
		chkb(pd, 1'h0);
		wf(k);
		chkb(al, 1'h1);
		wf(k + 1);
		chkb(al, 1'h0);
		wrr(3'h1, 16'h0583);
		$display("test queue end");
	endtask
	// ==========================================
	// Verdict, clock, watchdog and sequence
	task automatic conclude;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		num_errors++;
		conclude;
	end
	initial
	begin
		{rst, wr, rd, ara_s, ara_n} = 5'h10;
		sda_x = 1'h0;
		addr = 3'h0;
		wd = 16'h0000;
		val = 16'h0000;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_single;
		t_hold;
		t_ready;
		t_irq;
		t_queue;
		conclude;
	end
endmodule
